/* design/audio_pkg.sv */
// Shared constants, types and length decoding for the audio serial port
package audio_pkg;

  typedef enum logic [1:0] {FMT_STD, FMT_LJ, FMT_TDM} fmt_t;

  // Length field codes, shared by word length and slot length
  localparam logic [2:0] LEN_8 = 3'h0;
  localparam logic [2:0] LEN_16 = 3'h1;
  localparam logic [2:0] LEN_18 = 3'h2;
  localparam logic [2:0] LEN_20 = 3'h3;
  localparam logic [2:0] LEN_24 = 3'h4;
  localparam logic [2:0] LEN_32 = 3'h5;

  localparam int SAMPLE_W = 32;
  localparam int FIFO_DEPTH = 8;
  localparam logic [5:0] TDM_SLOT_BITS = 6'h20;
  localparam logic [3:0] TDM_SLOTS = 4'h8;
  localparam logic [3:0] STD_SLOTS = 4'h2;
  localparam logic [4:0] BIT_RST = 5'h00;
  localparam logic [2:0] SLOT_RST = 3'h0;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic WS_RST = 1'b0;

  function automatic logic [5:0] len_of(input logic [2:0] code);
    case (code)
      LEN_8: len_of = 6'h08;
      LEN_16: len_of = 6'h10;
      LEN_18: len_of = 6'h12;
      LEN_20: len_of = 6'h14;
      LEN_24: len_of = 6'h18;
      default: len_of = 6'h20;
    endcase
  endfunction

endpackage

/* design/sample_fifo.sv */
// Sample FIFO with registered read data and registered full flag
module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic full_q;
  logic push;
  logic pop;

  assign in_ready = !full_q;
  assign push = in_valid && !full_q;
  // The output stage refills whenever it is empty or being drained
  assign pop = (cnt_q != '0) && (!out_valid || out_ready);

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
      full_q <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      cnt_q <= cnt_d;
      full_q <= (cnt_d == (AW+1)'(DEPTH));
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem_q[rd_ptr_q];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule

/* design/audio_serial_port.sv */
// Audio serial port: independent transmit and receive with standard, LJ and TDM framing
//
// How it works
// - a master direction drives its own bit clock and word select.
// - transmit and receive each carry their own format and role.
// - every format runs in both master and slave role.
// - formats are standard two-channel, left-justified and eight-slot TDM.
// - each direction's format port selects its framing.
// - one master_slave_select bit per direction sets its role.
// - word length selectable as 8, 16, 18, 20, 24 or 32 bits.
// - slot length likewise selectable, forced to 32 bits in TDM.
// - separate FIFOs buffer transmit and receive samples.
// - control, status and both FIFO ports sit on the host side.
// - bit timing may come from an external master clock pin.
// - a programmable divider derives the bit clock from the source clock.
// - standard: word select low left, high right, one bit early, MSB first.
// - data and word select change on falling edge, sampled on rising.
// - left-justified: word select high left, changes at the first data bit.
// - TDM frame is eight 32-bit slots; active slots come first.
module audio_serial_port (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mclk_i,
  input wire logic tx_enable,
  input wire logic tx_master_slave_select,
  input wire audio_pkg::fmt_t tx_format,
  input wire logic [2:0] tx_word_len,
  input wire logic [2:0] tx_slot_len,
  input wire logic [2:0] tx_chan_count,
  input wire logic tx_fill_one,
  input wire logic tx_clk_ext,
  input wire logic [7:0] tx_clk_div,
  input wire logic rx_enable,
  input wire logic rx_master_slave_select,
  input wire audio_pkg::fmt_t rx_format,
  input wire logic [2:0] rx_word_len,
  input wire logic [2:0] rx_slot_len,
  input wire logic [2:0] rx_chan_count,
  input wire logic rx_clk_ext,
  input wire logic [7:0] rx_clk_div,
  input wire logic tx_sck_i,
  output logic tx_sck_o,
  output logic tx_sck_oe_n,
  input wire logic tx_ws_i,
  output logic tx_ws_o,
  output logic tx_ws_oe_n,
  output logic tx_sd_o,
  input wire logic rx_sck_i,
  output logic rx_sck_o,
  output logic rx_sck_oe_n,
  input wire logic rx_ws_i,
  output logic rx_ws_o,
  output logic rx_ws_oe_n,
  input wire logic rx_sd_i,
  input wire logic [31:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [31:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic clr_tx_underrun,
  input wire logic clr_rx_overflow,
  output logic tx_underrun,
  output logic rx_overflow
);

  ////////////////////////////////////////////////////////////////////////////
  // Per-direction configuration, index 0 is transmit and 1 is receive

  logic [1:0] en;
  logic [1:0] master;
  logic [1:0] ext;
  audio_pkg::fmt_t fmt [2];
  logic [1:0][5:0] wlen;
  logic [1:0][5:0] slen;
  logic [1:0][3:0] nslots;
  logic [1:0][3:0] nact;
  logic [1:0][7:0] div;

  assign en = {rx_enable, tx_enable};
  assign master = {rx_master_slave_select, tx_master_slave_select};
  assign ext = {rx_clk_ext, tx_clk_ext};
  assign fmt[0] = tx_format;
  assign fmt[1] = rx_format;
  assign div[0] = tx_clk_div;
  assign div[1] = rx_clk_div;

  always_comb begin
    for (int d = 0; d < 2; d++) begin
      wlen[d] = audio_pkg::len_of(d == 0 ? tx_word_len : rx_word_len);
      if (fmt[d] == audio_pkg::FMT_TDM) begin
        slen[d] = audio_pkg::TDM_SLOT_BITS;
        nslots[d] = audio_pkg::TDM_SLOTS;
        nact[d] = {1'b0, d == 0 ? tx_chan_count : rx_chan_count} + 4'h1;
      end else begin
        slen[d] = audio_pkg::len_of(d == 0 ? tx_slot_len : rx_slot_len);
        nslots[d] = audio_pkg::STD_SLOTS;
        nact[d] = audio_pkg::STD_SLOTS;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: {mclk, tx_sck, tx_ws, rx_sck, rx_ws, rx_sd}

  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  logic [5:0] pin_s3_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_s1_q <= 6'h00;
      pin_s2_q <= 6'h00;
      pin_s3_q <= 6'h00;
    end else begin
      pin_s1_q <= {mclk_i, tx_sck_i, tx_ws_i, rx_sck_i, rx_ws_i, rx_sd_i};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  logic mclk_rise;
  logic [1:0] sck_s;
  logic [1:0] sck_p;
  logic [1:0] ws_s;
  logic rx_sd_s;

  assign mclk_rise = pin_s2_q[5] && !pin_s3_q[5];
  assign sck_s = {pin_s2_q[2], pin_s2_q[4]};
  assign sck_p = {pin_s3_q[2], pin_s3_q[4]};
  assign ws_s = {pin_s2_q[1], pin_s2_q[3]};
  assign rx_sd_s = pin_s2_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // Bit clock generation and edge events

  logic [1:0][7:0] div_cnt_q;
  logic [1:0] sck_q;
  logic [1:0] src_tick;
  logic [1:0] half_done;
  logic [1:0] rise;
  logic [1:0] fall;

  always_comb begin
    for (int d = 0; d < 2; d++) begin
      src_tick[d] = ext[d] ? mclk_rise : 1'b1;
      half_done[d] = en[d] && master[d] && src_tick[d] && (div_cnt_q[d] == div[d]);
      // Slave edges come from the synchronised pin, so they lag the wire by two cycles
      rise[d] = master[d] ? (half_done[d] && !sck_q[d])
                          : (en[d] && sck_s[d] && !sck_p[d]);
      fall[d] = master[d] ? (half_done[d] && sck_q[d])
                          : (en[d] && !sck_s[d] && sck_p[d]);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_cnt_q <= '0;
      sck_q <= 2'h0;
    end else begin
      for (int d = 0; d < 2; d++) begin
        if (!en[d] || !master[d]) begin
          div_cnt_q[d] <= audio_pkg::DIV_RST;
          sck_q[d] <= 1'b0;
        end else if (half_done[d]) begin
          div_cnt_q[d] <= audio_pkg::DIV_RST;
          sck_q[d] <= !sck_q[d];
        end else if (src_tick[d]) begin
          div_cnt_q[d] <= div_cnt_q[d] + 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame position: bit within slot and slot within frame of the current bit

  logic [1:0][4:0] bit_q;
  logic [1:0][2:0] slot_q;
  logic [1:0] ws_prev_q;
  logic [1:0] ws_q;
  logic [1:0][7:0] pos_nx;
  logic [1:0][7:0] pos_eff;
  logic [1:0][7:0] pos_init;

  function automatic logic [7:0] pos_next(input logic [4:0] b, input logic [2:0] s,
                                          input logic [5:0] sl, input logic [3:0] ns);
    if ({1'b0, b} == sl - 6'h01) begin
      pos_next = {(({1'b0, s} == ns - 4'h1) ? 3'h0 : s + 3'h1), 5'h00};
    end else begin
      pos_next = {s, b + 5'h01};
    end
  endfunction

  // Word select level while the given position is on the wire
  function automatic logic ws_level(input audio_pkg::fmt_t f, input logic [7:0] p,
                                    input logic [7:0] pn);
    case (f)
      audio_pkg::FMT_STD: ws_level = pn[5];
      audio_pkg::FMT_LJ: ws_level = (p[7:5] == 3'h0);
      default: ws_level = (p[7:5] == 3'h0);
    endcase
  endfunction

  always_comb begin
    for (int d = 0; d < 2; d++) begin
      pos_nx[d] = pos_next(bit_q[d], slot_q[d], slen[d], nslots[d]);
      pos_init[d] = {nslots[d][2:0] - 3'h1, slen[d][4:0] - 5'h01};
      pos_eff[d] = {slot_q[d], bit_q[d]};
      // A slave locks onto word select edges sampled at the rising edge
      if (!master[d] && ws_s[d] != ws_prev_q[d]) begin
        case (fmt[d])
          audio_pkg::FMT_STD: pos_eff[d] = {2'h0, !ws_s[d], slen[d][4:0] - 5'h01};
          audio_pkg::FMT_LJ: pos_eff[d] = {2'h0, !ws_s[d], 5'h00};
          default: begin
            if (ws_s[d]) begin
              pos_eff[d] = {audio_pkg::SLOT_RST, audio_pkg::BIT_RST};
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bit_q <= '0;
      slot_q <= '0;
      ws_prev_q <= 2'h0;
    end else begin
      for (int d = 0; d < 2; d++) begin
        if (!en[d]) begin
          {slot_q[d], bit_q[d]} <= pos_init[d];
          ws_prev_q[d] <= audio_pkg::WS_RST;
        end else if (fall[d]) begin
          {slot_q[d], bit_q[d]} <= pos_nx[d];
        end else if (rise[d]) begin
          {slot_q[d], bit_q[d]} <= pos_eff[d];
          ws_prev_q[d] <= ws_s[d];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ws_q <= {audio_pkg::WS_RST, audio_pkg::WS_RST};
    end else begin
      for (int d = 0; d < 2; d++) begin
        if (!en[d] || !master[d]) begin
          ws_q[d] <= audio_pkg::WS_RST;
        end else if (fall[d]) begin
          ws_q[d] <= ws_level(fmt[d], pos_nx[d], pos_next(pos_nx[d][4:0], pos_nx[d][7:5],
                              slen[d], nslots[d]));
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers; enables are low while a master drives the pin

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_sck_oe_n <= 1'b1;
      tx_ws_oe_n <= 1'b1;
      rx_sck_oe_n <= 1'b1;
      rx_ws_oe_n <= 1'b1;
    end else begin
      tx_sck_oe_n <= !(tx_enable && tx_master_slave_select);
      tx_ws_oe_n <= !(tx_enable && tx_master_slave_select);
      rx_sck_oe_n <= !(rx_enable && rx_master_slave_select);
      rx_ws_oe_n <= !(rx_enable && rx_master_slave_select);
    end
  end

  assign tx_sck_o = sck_q[0];
  assign rx_sck_o = sck_q[1];
  assign tx_ws_o = ws_q[0];
  assign rx_ws_o = ws_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Transmit data path

  logic [31:0] tx_word;
  logic tx_word_valid;
  logic tx_take;
  logic tx_slot_start;
  logic tx_active;
  logic [31:0] tx_fill;
  logic [31:0] tx_load;
  logic [31:0] tx_sh_q;
  logic tx_sd_q;

  assign tx_fill = {32{tx_fill_one}};
  assign tx_slot_start = fall[0] && (pos_nx[0][4:0] == 5'h00);
  assign tx_active = ({1'b0, pos_nx[0][7:5]} < nact[0]);
  assign tx_take = tx_slot_start && tx_active && tx_word_valid;
  // Left-align the sample so the MSB leaves first and fill bits trail it
  assign tx_load = tx_take ? ((tx_word << (6'h20 - wlen[0])) | (tx_fill >> wlen[0]))
                           : tx_fill;

  sample_fifo #(
    .WIDTH(audio_pkg::SAMPLE_W),
    .DEPTH(audio_pkg::FIFO_DEPTH)
  ) tx_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_data(tx_data),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(tx_word),
    .out_valid(tx_word_valid),
    .out_ready(tx_take)
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_sh_q <= 32'h00000000;
      tx_sd_q <= 1'b0;
    end else if (!tx_enable) begin
      tx_sh_q <= 32'h00000000;
      tx_sd_q <= 1'b0;
    end else if (tx_slot_start) begin
      tx_sd_q <= tx_load[31];
      tx_sh_q <= {tx_load[30:0], tx_fill_one};
    end else if (fall[0]) begin
      tx_sd_q <= tx_sh_q[31];
      tx_sh_q <= {tx_sh_q[30:0], tx_fill_one};
    end
  end

  assign tx_sd_o = tx_sd_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_underrun <= 1'b0;
    end else if (tx_slot_start && tx_active && !tx_word_valid) begin
      tx_underrun <= 1'b1;
    end else if (clr_tx_underrun) begin
      tx_underrun <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive data path

  logic [31:0] rx_sh_q;
  logic [31:0] rx_word;
  logic rx_last;
  logic rx_push;
  logic rx_room;
  logic rx_seen_q;

  always_comb begin
    rx_word = rx_sh_q;
    if (pos_eff[1][4:0] == 5'h00) begin
      rx_word = {31'h00000000, rx_sd_s};
    end else if ({1'b0, pos_eff[1][4:0]} < wlen[1]) begin
      rx_word = {rx_sh_q[30:0], rx_sd_s};
    end
  end

  assign rx_last = ({1'b0, pos_eff[1][4:0]} == slen[1] - 6'h01);
  assign rx_push = rise[1] && rx_seen_q && rx_last
                   && ({1'b0, pos_eff[1][7:5]} < nact[1]);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_sh_q <= 32'h00000000;
    end else if (rise[1]) begin
      rx_sh_q <= rx_word;
    end
  end

  // Nothing is pushed until a slot start was caught, so a sync jump adds no phantom word
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_seen_q <= 1'b0;
    end else if (!rx_enable) begin
      rx_seen_q <= 1'b0;
    end else if (rise[1] && pos_eff[1][4:0] == 5'h00) begin
      rx_seen_q <= 1'b1;
    end
  end

  sample_fifo #(
    .WIDTH(audio_pkg::SAMPLE_W),
    .DEPTH(audio_pkg::FIFO_DEPTH)
  ) rx_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_data(rx_word),
    .in_valid(rx_push),
    .in_ready(rx_room),
    .out_data(rx_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  // The serial side cannot be stalled, so a word meeting a full FIFO is dropped
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_overflow <= 1'b0;
    end else if (rx_push && !rx_room) begin
      rx_overflow <= 1'b1;
    end else if (clr_rx_overflow) begin
      rx_overflow <= 1'b0;
    end
  end

endmodule

/* testbench/audio_port_checker.sv */
// Pin and stream checks for the audio serial port
module audio_port_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tx_enable,
  input wire logic tx_master_slave_select,
  input wire logic tx_clk_ext,
  input wire logic [7:0] tx_clk_div,
  input wire logic rx_enable,
  input wire logic rx_master_slave_select,
  input wire logic tx_sck_o,
  input wire logic tx_sck_oe_n,
  input wire logic tx_ws_o,
  input wire logic tx_ws_oe_n,
  input wire logic tx_sd_o,
  input wire logic rx_sck_oe_n,
  input wire logic [31:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic clr_tx_underrun,
  input wire logic clr_rx_overflow,
  input wire logic tx_underrun,
  input wire logic rx_overflow
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [8:0] gap_q;
  logic seen_q;
  logic sck_q;
  logic run;
  assign run = tx_enable && tx_master_slave_select;
  ////////////////////////////////
  // The first toggle after enable is not timed: its start phase is free
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gap_q <= 9'h000;
      seen_q <= 1'b0;
    end else if (!tx_enable) begin
      gap_q <= 9'h000;
      seen_q <= 1'b0;
    end else if (tx_sck_o != sck_q) begin
      gap_q <= 9'h000;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 9'h001;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= tx_sck_o;
    end
  end
  ////////////////////////////////
  a_tx_oe_on: assert property (run |=> !tx_sck_oe_n && !tx_ws_oe_n)
    else $error("tx pins not driven in master role");
  a_tx_oe_off: assert property (!run |=> tx_sck_oe_n && tx_ws_oe_n)
    else $error("tx pins driven outside master role");
  a_rx_oe_role: assert property (rx_sck_oe_n == !$past(rx_enable && rx_master_slave_select))
    else $error("rx clock enable does not follow role");
  a_idle_low: assert property (!tx_enable |=> !tx_sck_o && !tx_ws_o)
    else $error("tx clock or select not parked low");
  a_ws_on_fall: assert property (run && $past(run) && $changed(tx_ws_o) |-> $fell(tx_sck_o))
    else $error("tx select moved off a falling edge");
  a_sd_on_fall: assert property (run && $past(run) && $changed(tx_sd_o) |-> $fell(tx_sck_o))
    else $error("tx data moved off a falling edge");
  a_sck_half_period: assert property (run && !tx_clk_ext && seen_q && (tx_sck_o != sck_q)
    |-> gap_q == {1'b0, tx_clk_div})
    else $error("tx bit clock half period wrong");
  a_rx_word_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("rx word dropped before taken");
  a_urun_sticky: assert property (tx_underrun && !clr_tx_underrun |=> tx_underrun)
    else $error("underrun flag lost");
  a_ovf_sticky: assert property (rx_overflow && !clr_rx_overflow |=> rx_overflow)
    else $error("overflow flag lost");
endmodule

/* testbench/audio_codec_model.sv */
// Codec model: listens to the transmitter and masters the receiver
module audio_codec_model (
  input wire logic tx_sck_o,
  input wire logic tx_sck_oe_n,
  input wire logic tx_ws_o,
  input wire logic tx_sd_o,
  output logic rx_sck,
  output logic rx_ws,
  output logic rx_sd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic bits[$];
  logic wss[$];
  logic synced = 1'b0;
  initial begin
    rx_sck = 1'b0;
    rx_ws = 1'b0;
    rx_sd = 1'b0;
  end
  // Sample as a receiver does, on the rising bit clock edge
  always @(posedge tx_sck_o) begin
    if (tx_sck_oe_n === 1'b0) begin
      bits.push_back(tx_sd_o);
      wss.push_back(tx_ws_o);
    end
  end
  // One standard frame, 16-bit words in 32-bit slots; two lead bits on the first frame
  // give the sync edge, later frames follow on without a stray select pulse
  task automatic send_std(input logic [15:0] l, input logic [15:0] r);
    logic [63:0] f;
    f = {l, 16'h0000, r, 16'h0000};
    for (int j = synced ? 0 : -2; j < 64; j++) begin
      rx_sck = 1'b0;
      rx_ws = (j == -2) || (j >= 31 && j < 63);
      rx_sd = (j < 0) ? 1'b0 : f[63-j];
      #20;
      rx_sck = 1'b1;
      #20;
    end
    rx_sck = 1'b0;
    synced = 1'b1;
    // Released line shows the inverse so a stale bit never passes
    rx_sd = ~rx_sd;
  endtask
endmodule

/* testbench/audio_serial_port_test.sv */
// Self-checking bench for the audio serial port
module audio_serial_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic mclk_i = 1'b0;
  logic rst = 1'b1;
  logic tx_enable, tx_master_slave_select, tx_fill_one, tx_clk_ext, rx_enable, rx_clk_ext;
  logic rx_master_slave_select, tx_sck_i, tx_ws_i, tx_valid, rx_ready, rx_sck_i, rx_ws_i;
  logic clr_tx_underrun, clr_rx_overflow, rx_sd_i, tx_sck_o, tx_sck_oe_n, tx_ws_o, tx_sd_o;
  logic tx_ws_oe_n, rx_sck_o, rx_sck_oe_n, rx_ws_o, rx_ws_oe_n, tx_ready, rx_valid;
  logic tx_underrun, rx_overflow;
  audio_pkg::fmt_t tx_format, rx_format;
  logic [2:0] tx_word_len, tx_slot_len, tx_chan_count, rx_word_len, rx_slot_len, rx_chan_count;
  logic [7:0] tx_clk_div, rx_clk_div;
  logic [31:0] tx_data, rx_data;
  logic [31:0] wq[$];
  int lens[6] = '{8, 16, 18, 20, 24, 32};
  int miscompares = 0;
  int total_checks = 0;
  always #2.5 ref_clk = ~ref_clk;
  // Not a multiple of the system period, so source ticks drift against it
  always #8.1 mclk_i = ~mclk_i;
  audio_codec_model codec (.tx_sck_o(tx_sck_o), .tx_sck_oe_n(tx_sck_oe_n), .tx_ws_o(tx_ws_o),
    .tx_sd_o(tx_sd_o), .rx_sck(rx_sck_i), .rx_ws(rx_ws_i), .rx_sd(rx_sd_i));
  audio_serial_port DUT (.ref_clk(ref_clk), .rst(rst), .mclk_i(mclk_i), .tx_enable(tx_enable),
    .tx_master_slave_select(tx_master_slave_select), .tx_format(tx_format),
    .tx_word_len(tx_word_len), .tx_slot_len(tx_slot_len), .tx_chan_count(tx_chan_count),
    .tx_fill_one(tx_fill_one), .tx_clk_ext(tx_clk_ext), .tx_clk_div(tx_clk_div),
    .rx_enable(rx_enable), .rx_master_slave_select(rx_master_slave_select),
    .rx_format(rx_format), .rx_word_len(rx_word_len), .rx_slot_len(rx_slot_len),
    .rx_chan_count(rx_chan_count), .rx_clk_ext(rx_clk_ext), .rx_clk_div(rx_clk_div),
    .tx_sck_i(tx_sck_i), .tx_sck_o(tx_sck_o), .tx_sck_oe_n(tx_sck_oe_n), .tx_ws_i(tx_ws_i),
    .tx_ws_o(tx_ws_o), .tx_ws_oe_n(tx_ws_oe_n), .tx_sd_o(tx_sd_o), .rx_sck_i(rx_sck_i),
    .rx_sck_o(rx_sck_o), .rx_sck_oe_n(rx_sck_oe_n), .rx_ws_i(rx_ws_i), .rx_ws_o(rx_ws_o),
    .rx_ws_oe_n(rx_ws_oe_n), .rx_sd_i(rx_sd_i), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .clr_tx_underrun(clr_tx_underrun), .clr_rx_overflow(clr_rx_overflow),
    .tx_underrun(tx_underrun), .rx_overflow(rx_overflow));
  ////////////////////////////////
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask
  task automatic results();
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic timeout(input string n);
    $display("BAD %s expected done seen timeout", n);
    miscompares++;
    results();
  endtask
  task automatic push(input logic [31:0] w);
    tx_data = w;
    tx_valid = 1'b1;
    for (int n = 0; n <= 20; n++) begin
      if (n == 20) timeout("tx_ready");
      if (tx_ready === 1'b1) break;
      tick();
    end
    tick();
  endtask
  task automatic pop(input logic [31:0] e);
    for (int n = 0; n <= 20; n++) begin
      if (n == 20) timeout("rx_valid");
      tick();
      if (rx_valid === 1'b1) break;
    end
    check("rx_data", e, rx_data);
    rx_ready = 1'b1;
    tick();
    rx_ready = 1'b0;
  endtask
  // Bit 0 caught by the model is the rising edge before the first data bit
  task automatic check_tx(input int wl, input int sl, input int nact, input logic urun);
    int sb, fb, s, b;
    logic e;
    sb = (tx_format == audio_pkg::FMT_TDM) ? 32 : sl;
    fb = (tx_format == audio_pkg::FMT_TDM) ? 256 : 2 * sb;
    for (int n = 0; codec.bits.size() < fb + 2; n++) begin
      if (n == 5000) timeout("tx frame");
      tick();
    end
    tick();
    for (int i = 0; i < fb; i++) begin
      s = i / sb;
      b = i % sb;
      e = (s >= nact || b >= wl) ? tx_fill_one : wq[s][wl-1-b];
      check("tx_sd_o", e, codec.bits[i+1]);
      e = (tx_format == audio_pkg::FMT_STD) ? ((i + 1) % fb >= sb) : (s == 0);
      check("tx_ws_o", e, codec.wss[i+1]);
    end
    check("tx_underrun", urun, tx_underrun);
    tx_enable = 1'b0;
    clr_tx_underrun = 1'b1;
    tick();
    clr_tx_underrun = 1'b0;
    tick();
    check("tx_underrun", 0, tx_underrun);
    codec.bits.delete();
    codec.wss.delete();
  endtask
  ////////////////////////////////
  initial begin
    {tx_enable, tx_master_slave_select, tx_fill_one, tx_clk_ext, rx_enable, rx_clk_ext} = '0;
    {rx_master_slave_select, tx_sck_i, tx_ws_i, tx_valid, rx_ready} = '0;
    {clr_tx_underrun, clr_rx_overflow} = '0;
    tx_format = audio_pkg::FMT_STD;
    rx_format = audio_pkg::FMT_STD;
    {tx_word_len, tx_slot_len, tx_chan_count, rx_word_len, rx_slot_len, rx_chan_count} = '0;
    {tx_clk_div, tx_data} = '0;
    rx_clk_div = 8'h02;
    repeat (4) @(posedge ref_clk);
    #1;
    check("tx_ready", 1, tx_ready);
    check("rx_valid", 0, rx_valid);
    check("tx_sck_oe_n", 1, tx_sck_oe_n);
    rst = 1'b0;
    rx_enable = 1'b1;
    rx_master_slave_select = 1'b1;
    rx_format = audio_pkg::FMT_TDM;
    repeat (3) tick();
    check("rx_sck_oe_n", 0, rx_sck_oe_n);
    {rx_enable, rx_master_slave_select} = '0;
    rx_format = audio_pkg::FMT_STD;
    // Fill the transmit buffer with the direction stopped, then send it as TDM
    tx_format = audio_pkg::FMT_TDM;
    tx_word_len = audio_pkg::LEN_32;
    tx_chan_count = 3'h7;
    {tx_clk_ext, tx_master_slave_select, tx_valid} = 3'h7;
    for (int k = 0; k < 12; k++) begin
      tx_data = 32'h9A5C_3E00 + 32'(k);
      if (tx_ready === 1'b1) wq.push_back(tx_data);
      tick();
    end
    tx_valid = 1'b0;
    check("tx fill", 9, 32'(wq.size()));
    tx_enable = 1'b1;
    check_tx(32, 32, 8, 1'b0);
    // Second reset; the word left over from the fill already went out in slot 0 of the next frame
    rst = 1'b1;
    tick();
    rst = 1'b0;
    check("tx_ready", 1, tx_ready);
    tx_clk_ext = 1'b0;
    tx_clk_div = 8'h01;
    for (int k = 0; k < 5; k++) begin
      tx_format = k[0] ? audio_pkg::FMT_LJ : audio_pkg::FMT_STD;
      tx_fill_one = k[0];
      tx_word_len = 3'(k);
      tx_slot_len = 3'(k + 1);
      wq = '{32'hA5C3_96E1, 32'h5A3C_691E};
      push(wq[0]);
      push(wq[1]);
      tx_valid = 1'b0;
      tx_enable = 1'b1;
      check_tx(lens[k], lens[k+1], 2, 1'b1);
    end
    // Receive as slave with the reader stalled, so the tenth word overflows
    rx_enable = 1'b1;
    rx_word_len = audio_pkg::LEN_16;
    rx_slot_len = audio_pkg::LEN_32;
    tick();
    for (int k = 0; k < 5; k++) begin
      codec.send_std(16'hA1E0 + 16'(k), 16'h5B70 + 16'(k));
    end
    repeat (4) tick();
    check("rx_overflow", 1, rx_overflow);
    for (int k = 0; k < 9; k++) begin
      pop(k[0] ? 32'h5B70 + 32'(k / 2) : 32'hA1E0 + 32'(k / 2));
    end
    clr_rx_overflow = 1'b1;
    tick();
    clr_rx_overflow = 1'b0;
    tick();
    check("rx_overflow", 0, rx_overflow);
    results();
  end
endmodule
bind audio_serial_port audio_port_checker chk (.ref_clk(ref_clk), .rst(rst),
  .tx_enable(tx_enable), .tx_master_slave_select(tx_master_slave_select),
  .tx_clk_ext(tx_clk_ext), .tx_clk_div(tx_clk_div), .rx_enable(rx_enable),
  .rx_master_slave_select(rx_master_slave_select), .tx_sck_o(tx_sck_o),
  .tx_sck_oe_n(tx_sck_oe_n), .tx_ws_o(tx_ws_o), .tx_ws_oe_n(tx_ws_oe_n), .tx_sd_o(tx_sd_o),
  .rx_sck_oe_n(rx_sck_oe_n), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .clr_tx_underrun(clr_tx_underrun), .clr_rx_overflow(clr_rx_overflow),
  .tx_underrun(tx_underrun), .rx_overflow(rx_overflow));
